// ===== design/i2cc_pkg.sv
// constants and types of the two-wire control-register block
// assumes a 100 MHz system clock and a byte-addressed register bus
package i2cc_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_MASK = 4'h8;
  // control bit positions
  localparam int CB_ON = 5;
  localparam int CB_GCA = 4;
  localparam int CB_START = 3;
  localparam int CB_ACK = 2;
  localparam int CB_STOP = 1;
  localparam int CB_IRQ = 0;
  // status bit positions, event pending reads at bit 7
  localparam int SB_START = 0;
  localparam int SB_HDR = 1;
  localparam int SB_BYTE = 2;
  localparam int SB_HIT = 3;
  localparam int SB_AACK = 4;
  localparam int SB_EVT = 7;
  // values after reset
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [4:0] STAT_RST = 5'h00;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [2:0] SYNC_RST = 3'h7;
  // bus condition timing
  localparam int CLK_NS = 10;
  localparam int T_COND_NS = 5000;
  localparam logic [9:0] T_COND_CYC = 10'((T_COND_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [9:0] CNT_ONE = 10'h001;
  typedef enum logic [2:0] {
    ENG_IDLE, ENG_RSTART, ENG_START, ENG_STOP1, ENG_STOP2
  } i2cc_eng_t;
  typedef struct packed {
    logic waitreq;
    logic [7:0] rdata;
    logic [5:0] ctl;
    logic [4:0] stat;
    logic [4:0] mask;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic busy;
    logic master;
    i2cc_eng_t eng;
    logic [9:0] cnt;
    logic addr_ok;
    logic gc_mode;
    logic release_l;
    logic scl_oe;
    logic sda_oe;
    logic ack;
    logic irq;
    logic pin_alt;
  } i2cc_state_t;
endpackage

// ===== design/i2cc_ctrl.sv
// control-register logic of a multimaster two-wire serial interface
// assumes the byte datapath sends one-cycle event pulses on ref_clk_i
`timescale 1ns/1ps
module i2cc_ctrl import i2cc_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic pin_alt_o,
  input wire logic header_sent_i,
  input wire logic byte_done_i,
  input wire logic addr_ack_i,
  input wire logic addr_valid_i,
  input wire logic [7:0] addr_byte_i,
  input wire logic own_addr_hit_i,
  output logic ack_o,
  output logic gc_mode_o,
  output logic tx_allow_o,
  output logic master_o,
  output logic irq_o
);
  i2cc_state_t s;
  i2cc_state_t n;
  logic wr;
  logic start_det;
  logic stop_det;
  logic start_done;
  logic gc_hit;
  logic stretch;
  logic scl_drv;
  logic sda_drv;
  logic [4:0] ev;

  // ==========================================================
  // helpers
  // write strobe landing on one register offset
  function automatic logic reg_wr(input logic wr_ok, input logic [3:0] adr,
                                  input logic [3:0] ofs);
    return wr_ok && (adr == ofs);
  endfunction

  // filtered level follows stages two and three once they agree
  function automatic logic pin_filt(input logic [2:0] sh, input logic prev);
    logic v;
    v = prev;
    if (sh[1] == sh[2]) begin
      v = sh[2];
    end
    return v;
  endfunction

  // lines pulled low in each engine phase, as {scl, sda}
  function automatic logic [1:0] eng_lines(input i2cc_eng_t e);
    logic [1:0] v;
    v = 2'b00;
    unique case (e)
      ENG_IDLE: v = 2'b00;
      ENG_RSTART: v = 2'b00;
      ENG_START: v = 2'b01;
      ENG_STOP1: v = 2'b11;
      ENG_STOP2: v = 2'b01;
      default: v = 2'b00;
    endcase
    return v;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    n = s;
    start_done = 1'b0;
    gc_hit = 1'b0;
    // pin sampling, change taken once stages two and three agree
    n.scl_s = {s.scl_s[1:0], scl_i};
    n.sda_s = {s.sda_s[1:0], sda_i};
    n.scl_f = pin_filt(s.scl_s, s.scl_f);
    n.sda_f = pin_filt(s.sda_s, s.sda_f);
    start_det = s.scl_f & n.scl_f & s.sda_f & ~n.sda_f;
    stop_det = s.scl_f & n.scl_f & ~s.sda_f & n.sda_f;
    // busy bus holds off a slave start until a stop is seen
    if (start_det) begin
      n.busy = 1'b1;
    end else if (stop_det) begin
      n.busy = 1'b0;
    end

    // ==========================================================
    // register bus
    wr = write_i & ~s.waitreq;
    // request taken while waitrequest high, answered next cycle
    // data latched at the take edge stands through the answer cycle
    if ((read_i | write_i) & s.waitreq) begin
      n.waitreq = 1'b0;
      unique case (address_i)
        OFS_CTRL: n.rdata = {2'b00, s.ctl};
        OFS_STAT: n.rdata = {|s.stat, 2'b00, s.stat};
        OFS_MASK: n.rdata = {3'b000, s.mask};
        default: n.rdata = 8'h00;
      endcase
    end else begin
      n.waitreq = 1'b1;
    end
    if (reg_wr(wr, address_i, OFS_CTRL)) begin
      // from off only enable lands; a second write loads the rest
      if (!s.ctl[CB_ON]) begin
        n.ctl[CB_ON] = writedata_i[CB_ON];
      end else begin
        n.ctl = writedata_i[5:0];
      end
    end
    if (reg_wr(wr, address_i, OFS_MASK)) begin
      n.mask = writedata_i[4:0];
    end

    // ==========================================================
    // address phase
    if (addr_valid_i & s.ctl[CB_ON]) begin
      // general call read (01h) is never accepted
      if (addr_byte_i[7:1] == 7'h00) begin
        gc_hit = ~addr_byte_i[0] & s.ctl[CB_GCA];
        n.addr_ok = gc_hit;
        n.gc_mode = gc_hit;
      end else begin
        n.addr_ok = own_addr_hit_i;
        n.gc_mode = 1'b0;
      end
    end
    // a stop on the bus ends any addressed transfer
    if (stop_det) begin
      n.addr_ok = 1'b0;
      n.gc_mode = 1'b0;
    end

    // ==========================================================
    // start and stop engine
    // hold counter saturates at zero
    n.cnt = (s.cnt == CNT_ZERO) ? CNT_ZERO : 10'(s.cnt - CNT_ONE);
    unique case (s.eng)
      ENG_IDLE: begin
        if (s.ctl[CB_ON] & s.ctl[CB_START]) begin
          if (s.master) begin
            n.eng = ENG_RSTART;
            n.cnt = T_COND_CYC;
          end else if (!s.busy) begin
            n.eng = ENG_START;
            n.cnt = T_COND_CYC;
          end
        end else if (s.ctl[CB_ON] & s.master & s.ctl[CB_STOP] &
                     (s.stat[SB_BYTE] | s.stat[SB_START])) begin
          n.eng = ENG_STOP1;
          n.cnt = T_COND_CYC;
        end
      end
      // both lines released for a full hold before the new start
      ENG_RSTART: begin
        if (s.cnt == CNT_ZERO) begin
          n.eng = ENG_START;
          n.cnt = T_COND_CYC;
        end
      end
      // sda low with scl released marks the start
      ENG_START: begin
        if (s.cnt == CNT_ZERO) begin
          n.eng = ENG_IDLE;
          start_done = 1'b1;
          n.ctl[CB_START] = 1'b0;
          n.master = 1'b1;
        end
      end
      // both lines low, then scl released ahead of sda
      ENG_STOP1: begin
        if (s.cnt == CNT_ZERO) begin
          n.eng = ENG_STOP2;
          n.cnt = T_COND_CYC;
        end
      end
      // cleared flags keep scl free once the stop is out
      ENG_STOP2: begin
        if (s.cnt == CNT_ZERO) begin
          n.eng = ENG_IDLE;
          n.ctl[CB_STOP] = 1'b0;
          n.master = 1'b0;
          n.stat[SB_BYTE] = 1'b0;
          n.stat[SB_START] = 1'b0;
        end
      end
      default: n.eng = ENG_IDLE;
    endcase

    // slave release held until software drops the stop bit
    if (~s.master & s.ctl[CB_STOP] & byte_done_i) begin
      n.release_l = 1'b1;
    end
    if (!n.ctl[CB_STOP]) begin
      n.release_l = 1'b0;
    end

    // ==========================================================
    // sticky events, set wins over write-one-clear
    ev = 5'h00;
    ev[SB_START] = start_done;
    ev[SB_HDR] = header_sent_i;
    ev[SB_BYTE] = byte_done_i;
    ev[SB_HIT] = (addr_valid_i & own_addr_hit_i) | gc_hit;
    ev[SB_AACK] = addr_ack_i;
    if (reg_wr(wr, address_i, OFS_STAT)) begin
      n.stat = n.stat & ~writedata_i[4:0];
    end
    // events are dropped while disabled
    if (s.ctl[CB_ON]) begin
      n.stat = n.stat | ev;
    end

    // ==========================================================
    // disable clears the other control bits, status, engine and modes; stop bit and mask kept
    if (!n.ctl[CB_ON]) begin
      n.ctl[CB_GCA] = 1'b0;
      n.ctl[CB_START] = 1'b0;
      n.ctl[CB_ACK] = 1'b0;
      n.ctl[CB_IRQ] = 1'b0;
      n.stat = STAT_RST;
      n.eng = ENG_IDLE;
      n.master = 1'b0;
      n.addr_ok = 1'b0;
      n.gc_mode = 1'b0;
      n.release_l = 1'b0;
    end

    // ==========================================================
    // registered outputs
    {scl_drv, sda_drv} = eng_lines(n.eng);
    // stretch held off while the engine owns the lines
    stretch = (|n.stat) & (n.eng == ENG_IDLE);
    n.scl_oe = n.ctl[CB_ON] & ~n.release_l & (scl_drv | stretch);
    n.sda_oe = n.ctl[CB_ON] & ~n.release_l & sda_drv;
    n.pin_alt = n.ctl[CB_ON];
    n.ack = n.ctl[CB_ON] & n.ctl[CB_ACK] & n.addr_ok & ~n.release_l;
    n.irq = n.ctl[CB_IRQ] & (|(n.stat & n.mask));
  end

  // ==========================================================
  // state register
  // lines idle high, so synchronisers reset high: no false edge
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.ctl <= CTRL_RST;
      s.stat <= STAT_RST;
      s.mask <= MASK_RST;
      s.scl_s <= SYNC_RST;
      s.sda_s <= SYNC_RST;
      s.scl_f <= 1'b1;
      s.sda_f <= 1'b1;
      s.eng <= ENG_IDLE;
      s.cnt <= CNT_ZERO;
    end else begin
      s <= n;
    end
  end

  assign readdata_o = {24'h000000, s.rdata};
  assign waitrequest_o = s.waitreq;
  // open-drain: only the enables move
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = s.scl_oe;
  assign sda_oe_o = s.sda_oe;
  assign pin_alt_o = s.pin_alt;
  assign ack_o = s.ack;
  assign gc_mode_o = s.gc_mode;
  // general call is receive only
  assign tx_allow_o = ~s.gc_mode;
  assign master_o = s.master;
  assign irq_o = s.irq;
endmodule

// ===== tb/i2cc_ctrl_props.sv
// port assertions for the two-wire control-register block
// assumes a bind onto i2cc_ctrl, single clock ref_clk_i
`timescale 1ns/1ps
module i2cc_ctrl_props import i2cc_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o,
  input wire logic pin_alt_o,
  input wire logic header_sent_i,
  input wire logic ack_o,
  input wire logic gc_mode_o,
  input wire logic tx_allow_o,
  input wire logic master_o,
  input wire logic irq_o
);
  // ==========
  // properties
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence req_s; (read_i || write_i) && waitrequest_o; endsequence
  sequence hold_s; sda_oe_o && !scl_oe_o; endsequence
  AST_WAIT: assert property (req_s |=> !waitrequest_o ##1 waitrequest_o)
    else $error("bus answer not one cycle");
  AST_RSV: assert property (read_i && !waitrequest_o && address_i == OFS_CTRL
    |-> readdata_o[7:6] == 2'h0) else $error("reserved bits not zero");
  AST_OFF: assert property (!pin_alt_o ##1 !pin_alt_o |-> !scl_oe_o && !sda_oe_o)
    else $error("lines driven while disabled");
  AST_IRQ: assert property (!pin_alt_o |=> !irq_o) else $error("irq while disabled");
  AST_ACK: assert property (!pin_alt_o |=> !ack_o) else $error("ack while disabled");
  AST_MST: assert property (!pin_alt_o |=> !master_o && !gc_mode_o)
    else $error("mode kept while disabled");
  AST_GC: assert property (tx_allow_o == !gc_mode_o) else $error("transmit in gc mode");
  AST_STR: assert property (pin_alt_o && header_sent_i && !sda_oe_o && !scl_oe_o
    |-> ##[1:3] scl_oe_o) else $error("clock not stretched");
  AST_START: assert property ($rose(sda_oe_o) && !scl_oe_o |-> hold_s[*8])
    else $error("start condition too short");
endmodule
bind i2cc_ctrl i2cc_ctrl_props u_props (
  .ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i),
  .address_i(address_i),
  .read_i(read_i),
  .write_i(write_i),
  .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o),
  .scl_oe_o(scl_oe_o),
  .sda_oe_o(sda_oe_o),
  .pin_alt_o(pin_alt_o),
  .header_sent_i(header_sent_i),
  .ack_o(ack_o),
  .gc_mode_o(gc_mode_o),
  .tx_allow_o(tx_allow_o),
  .master_o(master_o),
  .irq_o(irq_o)
);

// ===== tb/i2cc_bus_model.sv
// far devices on the two-wire bus: idle, lines pulled up
// assumes open-drain lines, high enable pulls low
`timescale 1ns/1ps
module i2cc_bus_model (
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  // wired-and with pull-ups
  assign scl_o = ~scl_oe_i;
  assign sda_o = ~sda_oe_i;
endmodule

// ===== tb/testbench.sv
// self-checking bench for the control-register block
// assumes the idle bus model on the far side
`timescale 1ns/1ps
module testbench;
  import i2cc_pkg::*;
  logic ref_clk_i, resetn_i, read_i, write_i, waitrequest_o;
  logic [3:0] address_i;
  logic [31:0] writedata_i, readdata_o, rd;
  logic scl, sda, scl_oe, sda_oe, pin_alt, ack, gc, tx, mst, irq, hs, bd, aa, av, hit;
  logic [7:0] ab;
  int n_fail, comparisons, cyc;
  i2cc_ctrl dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .scl_i(scl), .sda_i(sda), .scl_o(), .scl_oe_o(scl_oe),
    .sda_o(), .sda_oe_o(sda_oe), .pin_alt_o(pin_alt), .header_sent_i(hs), .byte_done_i(bd),
    .addr_ack_i(aa), .addr_valid_i(av), .addr_byte_i(ab), .own_addr_hit_i(hit), .ack_o(ack),
    .gc_mode_o(gc), .tx_allow_o(tx), .master_o(mst), .irq_o(irq));
  i2cc_bus_model bus (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  // ==========
  // tasks
  task close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    address_i <= a;
    writedata_i <= {24'h000000, d};
    write_i <= w;
    read_i <= !w;
    @(posedge ref_clk_i);
    while (waitrequest_o !== 1'b0) @(posedge ref_clk_i);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, 8'h00);
    chk("readdata", rd, e);
  endtask
  // pulse {hit, addr_valid, header, byte, addr_ack}
  task ev(input logic [4:0] e, input logic [7:0] b);
    @(posedge ref_clk_i);
    {hit, av, hs, bd, aa} <= e;
    ab <= b;
    @(posedge ref_clk_i);
    {hit, av, hs, bd, aa} <= 5'h00;
    repeat (3) @(posedge ref_clk_i);
  endtask
  // ==========
  // sequence
  initial begin
    {resetn_i, read_i, write_i, hs, bd, aa, av, hit} = 8'h00;
    address_i = 4'h0;
    writedata_i = 32'h00000000;
    ab = 8'h00;
    repeat (6) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rdc(OFS_CTRL, 32'h00);
    acc(1'b1, OFS_CTRL, 8'hFF);
    rdc(OFS_CTRL, 32'h20);
    chk("pin_alt", pin_alt, 1'b1);
    acc(1'b1, OFS_CTRL, 8'hF5);
    rdc(OFS_CTRL, 32'h35);
    acc(1'b1, OFS_MASK, 8'h1F);
    ev(5'h04, 8'h00);
    rdc(OFS_STAT, 32'h82);
    chk("irq scl_oe", {irq, scl_oe}, 2'h3);
    acc(1'b1, OFS_STAT, 8'h02);
    rdc(OFS_STAT, 32'h00);
    chk("irq", irq, 1'b0);
    ev(5'h08, 8'h00);
    chk("gc tx ack", {gc, tx, ack}, 3'h5);
    acc(1'b1, OFS_CTRL, 8'h02);
    rdc(OFS_CTRL, 32'h02);
    ev(5'h04, 8'h00);
    rdc(OFS_STAT, 32'h00);
    chk("off outputs", {pin_alt, gc, ack, irq, scl_oe}, 5'h00);
    acc(1'b1, OFS_CTRL, 8'h20);
    ev(5'h02, 8'h00);
    chk("slave release", {scl_oe, sda_oe}, 2'h0);
    rdc(OFS_CTRL, 32'h22);
    acc(1'b1, OFS_CTRL, 8'h21);
    rdc(OFS_STAT, 32'h84);
    chk("stretch irq", {scl_oe, irq}, 2'h3);
    acc(1'b1, OFS_CTRL, 8'h34);
    acc(1'b1, OFS_STAT, 8'h1F);
    ev(5'h08, 8'h01);
    chk("gc ack 01h", {gc, ack}, 2'h0);
    ev(5'h18, 8'h42);
    chk("ack own", ack, 1'b1);
    acc(1'b1, OFS_STAT, 8'h1F);
    acc(1'b1, OFS_CTRL, 8'h29);
    wait (mst === 1'b1);
    repeat (3) @(posedge ref_clk_i);
    rdc(OFS_CTRL, 32'h21);
    rdc(OFS_STAT, 32'h81);
    chk("start irq scl_oe", {irq, scl_oe, sda_oe}, 3'h6);
    acc(1'b1, OFS_STAT, 8'h1F);
    acc(1'b1, OFS_CTRL, 8'h29);
    repeat (4) @(posedge ref_clk_i);
    chk("rstart lines", {mst, scl_oe, sda_oe}, 3'h4);
    repeat (1100) @(posedge ref_clk_i);
    rdc(OFS_CTRL, 32'h21);
    rdc(OFS_STAT, 32'h81);
    acc(1'b1, OFS_CTRL, 8'h23);
    wait (mst === 1'b0);
    repeat (3) @(posedge ref_clk_i);
    rdc(OFS_CTRL, 32'h21);
    rdc(OFS_STAT, 32'h00);
    chk("stop lines", {scl_oe, sda_oe}, 2'h0);
    close_out();
  end
endmodule
